// File: inc/pin_group_defines.svh
// register indexes, field positions and counts for one pin group
`ifndef PIN_GROUP_DEFINES_SVH
`define PIN_GROUP_DEFINES_SVH
`define IDX_LEVEL 7'h20
`define IDX_SAMPCTL 7'h24
`define IDX_BATCH 7'h28
`define IDX_FSEL_BASE 7'h30
`define IDX_PCFG_BASE 7'h40
`define FSEL_COUNT 16
`define PCFG_COUNT 32
`define GROUP_SPAN 10'h080
`define BW_HALF 31
`define BW_APPLY_CFG 30
`define BW_APPLY_FS 28
`define BW_FS_HI 27
`define BW_FS_LO 24
`define BW_DRV 22
`define BW_PULL 18
`define BW_INPUT_BUFFER_ON 17
`define BW_FSON 16
`define PC_DRV 6
`define PC_PULL 2
`define PC_INPUT_BUFFER_ON 1
`define PC_FSON 0
`define FUNC_LAST 4'h8
`define STRB_ALL 4'hF
`define ZERO32 32'h00000000
`define ZERO8 8'h00
`endif

// File: inc/pin_group_pkg.sv
// types shared by the pin group logic
package pin_group_pkg;
   typedef struct packed {
      logic drive_strength;
      logic pull_resistor_on;
      logic input_buffer_on;
      logic function_select_on;
   } pin_cfg_type;
   typedef logic [3:0] func_code_type;
endpackage : pin_group_pkg

// File: hdl/pin_group_ctrl.sv
// register logic, input sampling and function mux of one 32-pin group
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "pin_group_defines.svh"
// Functional notes
// - sampled_level bit reads 0 for low, 1 for high sampled input.
// - sampling control at 0x24, bit per pin, 1 continuous, resets zero.
// - sampling mode applies to pins set as inputs by direction.
// - any continuous request in a byte lane samples the whole lane continuously.
// - batch write register takes full 32-bit writes only, narrower ignored.
// - reading the batch write register always returns zero.
// - bit 31 selects lower or upper sixteen pins.
// - bits 15:0 mask which pins of the half are updated.
// - bit 30 set loads pin settings of selected pins; clear changes none.
// - setting fields at bits 22,18,17,16 copy into pin settings.
// - bit 28 set loads function nibble of selected pins from bits 27:24.
// - sixteen byte function registers from 0x30, pair 2n and 2n+1.
// - high nibble odd pin, low nibble even, used only when enabled.
// - codes 0 to 8 pick functions A to I; 9 to F pick none.
// - each group has its own register set, groups 0x80 apart.
// - protected writes to sampling, batch and function registers are blocked.
// - thirty-two pin settings bytes from 0x40 with fields 6,2,1,0.
// - function enabled drives pad from peripheral, else from port registers.
module pin_group_ctrl (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // protection
   input wire logic write_protect_on,
   // port registers and pads
   input wire logic [31:0] port_dir,
   input wire logic [31:0] port_out,
   input wire logic [31:0] pad_in,
   // peripheral functions A..I
   input wire logic [8:0][31:0] func_oe,
   input wire logic [8:0][31:0] func_out,
   // pad controls
   output logic [31:0] pad_oe,
   output logic [31:0] pad_out,
   output pin_group_pkg::pin_cfg_type [31:0] pin_settings
);
   logic [31:0] samp_q;
   logic [31:0] level_q;
   logic [31:0] level_d;
   logic [31:0] prdata_q;
   logic [31:0] rd_d;
   logic [15:0][7:0] fsel_q;
   pin_group_pkg::pin_cfg_type [31:0] pcfg_q;
   logic [31:0] pad_oe_q;
   logic [31:0] pad_out_q;
   logic [6:0] idx;
   logic setup;
   logic wr;
   logic wr_ok;
   logic mapped;
   logic batch_wr;
   logic [31:0] batch_sel;
   logic demand;
   logic [3:0] lane_cont;
   logic [31:0] sample_now;
   logic [31:0] mux_oe;
   logic [31:0] mux_out;

   // offset within the group; group base decoded upstream into psel
   assign idx = paddr[8:2];
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;

   always_comb begin
      mapped = 1'b0;
      if (idx == `IDX_LEVEL) begin
         mapped = 1'b1;
      end else if (idx == `IDX_SAMPCTL) begin
         mapped = 1'b1;
      end else if (idx == `IDX_BATCH) begin
         mapped = 1'b1;
      end else if (idx >= `IDX_FSEL_BASE && idx < `IDX_FSEL_BASE + 7'(`FSEL_COUNT)) begin
         mapped = 1'b1;
      end else if (idx >= `IDX_PCFG_BASE && idx < `IDX_PCFG_BASE + 7'(`PCFG_COUNT)) begin
         mapped = 1'b1;
      end
   end

   // level is read-only; protected writes are refused with an error
   assign wr_ok = wr & mapped & ~write_protect_on & (idx != `IDX_LEVEL);
   assign pslverr = psel & penable & (~mapped | (pwrite & ~wr_ok));

   // narrow writes would tear the batch, so they do nothing
   assign batch_wr = wr_ok & (idx == `IDX_BATCH) & (pstrb == `STRB_ALL);
   assign batch_sel = pwdata[`BW_HALF] ? {pwdata[15:0], 16'h0000}
                                       : {16'h0000, pwdata[15:0]};

   // input sampling
   assign demand = setup & ~pwrite & (idx == `IDX_LEVEL);
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         lane_cont[k] = |samp_q[8*k +: 8];
      end
      for (int i = 0; i < 32; i++) begin
         // continuous mode only meaningful for input pins
         sample_now[i] = pcfg_q[i].input_buffer_on
                       & (demand | (~port_dir[i] & lane_cont[i/8]));
         level_d[i] = sample_now[i] ? pad_in[i] : level_q[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= `ZERO32;
      end else begin
         level_q <= level_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_q <= `ZERO32;
      end else if (wr_ok && idx == `IDX_SAMPCTL) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               samp_q[8*b +: 8] <= pwdata[8*b +: 8];
            end
         end
      end
   end

   // function select bytes: direct write or batch nibble update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_q <= '0;
      end else begin
         for (int n = 0; n < `FSEL_COUNT; n++) begin
            if (wr_ok && pstrb[0] && idx == `IDX_FSEL_BASE + 7'(n)) begin
               fsel_q[n] <= pwdata[7:0];
            end else if (batch_wr && pwdata[`BW_APPLY_FS]) begin
               // each pin owns one nibble only
               if (batch_sel[2*n]) begin
                  fsel_q[n][3:0] <= pwdata[`BW_FS_HI:`BW_FS_LO];
               end
               if (batch_sel[2*n+1]) begin
                  fsel_q[n][7:4] <= pwdata[`BW_FS_HI:`BW_FS_LO];
               end
            end
         end
      end
   end

   // pin settings: direct byte write or batch update, same edge as fsel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcfg_q <= '0;
      end else begin
         for (int p = 0; p < `PCFG_COUNT; p++) begin
            if (wr_ok && pstrb[0] && idx == `IDX_PCFG_BASE + 7'(p)) begin
               pcfg_q[p].drive_strength <= pwdata[`PC_DRV];
               pcfg_q[p].pull_resistor_on <= pwdata[`PC_PULL];
               pcfg_q[p].input_buffer_on <= pwdata[`PC_INPUT_BUFFER_ON];
               pcfg_q[p].function_select_on <= pwdata[`PC_FSON];
            end else if (batch_wr && pwdata[`BW_APPLY_CFG] && batch_sel[p]) begin
               pcfg_q[p].drive_strength <= pwdata[`BW_DRV];
               pcfg_q[p].pull_resistor_on <= pwdata[`BW_PULL];
               pcfg_q[p].input_buffer_on <= pwdata[`BW_INPUT_BUFFER_ON];
               pcfg_q[p].function_select_on <= pwdata[`BW_FSON];
            end
         end
      end
   end
   assign pin_settings = pcfg_q;

   // read mux, captured in the setup phase
   always_comb begin
      rd_d = `ZERO32;
      if (idx == `IDX_LEVEL) begin
         rd_d = level_d;
      end else if (idx == `IDX_SAMPCTL) begin
         rd_d = samp_q;
      end else if (idx == `IDX_BATCH) begin
         rd_d = `ZERO32;
      end else if (idx >= `IDX_FSEL_BASE && idx < `IDX_FSEL_BASE + 7'(`FSEL_COUNT)) begin
         rd_d = {24'h000000, fsel_q[4'(idx - `IDX_FSEL_BASE)]};
      end else if (idx >= `IDX_PCFG_BASE && idx < `IDX_PCFG_BASE + 7'(`PCFG_COUNT)) begin
         rd_d[`PC_DRV] = pcfg_q[5'(idx - `IDX_PCFG_BASE)].drive_strength;
         rd_d[`PC_PULL] = pcfg_q[5'(idx - `IDX_PCFG_BASE)].pull_resistor_on;
         rd_d[`PC_INPUT_BUFFER_ON] = pcfg_q[5'(idx - `IDX_PCFG_BASE)].input_buffer_on;
         rd_d[`PC_FSON] = pcfg_q[5'(idx - `IDX_PCFG_BASE)].function_select_on;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= `ZERO32;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_d;
      end
   end

   // per-pin function mux
   for (genvar g = 0; g < 32; g++) begin : g_pin
      pin_group_pkg::func_code_type code;
      logic valid;
      assign code = g[0] ? fsel_q[g/2][7:4] : fsel_q[g/2][3:0];
      assign valid = code <= `FUNC_LAST;
      always_comb begin
         if (pcfg_q[g].function_select_on) begin
            mux_oe[g] = valid ? func_oe[code][g] : 1'b0;
            mux_out[g] = valid ? func_out[code][g] : 1'b0;
         end else begin
            mux_oe[g] = port_dir[g];
            mux_out[g] = port_out[g];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_oe_q <= `ZERO32;
         pad_out_q <= `ZERO32;
      end else begin
         pad_oe_q <= mux_oe;
         pad_out_q <= mux_out;
      end
   end
   assign pad_oe = pad_oe_q;
   assign pad_out = pad_out_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   batch_read_zero_a: assert property (
      (psel && penable && !pwrite && idx == `IDX_BATCH) |-> prdata == `ZERO32)
      else $error("batch register read not zero");
   narrow_batch_a: assert property (
      (wr && idx == `IDX_BATCH && pstrb != `STRB_ALL)
      |=> ($stable(pcfg_q) && $stable(fsel_q)))
      else $error("narrow batch write changed state");
   protect_block_a: assert property (
      (wr && write_protect_on) |=> ($stable(samp_q) && $stable(fsel_q) && $stable(pcfg_q)))
      else $error("protected write changed state");
   lane_cont_a: assert property (
      (samp_q[7] && !port_dir[3] && pcfg_q[3].input_buffer_on)
      |=> level_q[3] == $past(pad_in[3]))
      else $error("continuous lane not sampled");
   demand_read_a: assert property (
      (demand && pcfg_q[5].input_buffer_on) ##1 (psel && penable)
      |-> prdata[5] == $past(pad_in[5]))
      else $error("on-demand read returned wrong level");
   apply_cfg_a: assert property (
      (batch_wr && pwdata[`BW_APPLY_CFG] && !pwdata[`BW_HALF] && pwdata[0])
      |=> (pcfg_q[0].drive_strength == $past(pwdata[`BW_DRV])
          && pcfg_q[0].function_select_on == $past(pwdata[`BW_FSON])))
      else $error("batch settings not loaded");
   apply_fs_a: assert property (
      (batch_wr && pwdata[`BW_APPLY_FS] && !pwdata[`BW_HALF] && pwdata[1] && !pwdata[0])
      |=> (fsel_q[0][7:4] == $past(pwdata[`BW_FS_HI:`BW_FS_LO])
          && $stable(fsel_q[0][3:0])))
      else $error("batch function nibble wrong");
   reserved_code_a: assert property (
      (pcfg_q[0].function_select_on && fsel_q[0][3:0] > `FUNC_LAST) |=> !pad_oe[0])
      else $error("reserved code drove pad");
   port_path_a: assert property (
      !pcfg_q[2].function_select_on |=> pad_oe[2] == $past(port_dir[2]))
      else $error("port registers not driving pad");

   batch_both_c: cover property (batch_wr && pwdata[`BW_APPLY_CFG] && pwdata[`BW_APPLY_FS]);
   protect_c: cover property (wr && write_protect_on);
   func_pad_c: cover property (pcfg_q[0].function_select_on && pad_oe[0]);
endmodule : pin_group_ctrl

// File: verification/pin_pad_model.sv
// pad levels and peripheral function outputs around one pin group
`timescale 1ns/1ns
module pin_pad_model (
   // clock and bench levels
   input wire logic pclk,
   input wire logic [31:0] level,
   // toward the pin group
   output logic [31:0] pad_in,
   output logic [8:0][31:0] func_oe,
   output logic [8:0][31:0] func_out
);
   // pads follow the bench one edge late, like a real pad ring
   always_ff @(posedge pclk) begin
      pad_in <= level;
   end
   // distinct pattern per function so a wrong pick shows
   always_comb begin
      for (int k = 0; k < 9; k++) begin
         func_out[k] = 32'h9E37_79B9 * (k + 1);
         func_oe[k] = func_out[k] ^ 32'hA5A5_A5A5;
      end
   end
endmodule : pin_pad_model

// File: verification/pin_group_sampling_and_mux_config_test.sv
// self-checking bench for the pin group register and mux logic
`timescale 1ns/1ns
module pin_group_sampling_and_mux_config_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, write_protect_on;
   logic [31:0] paddr, pwdata, prdata, port_dir, port_out, pad_in, pad_oe, pad_out, level;
   logic [3:0] pstrb;
   logic [8:0][31:0] func_oe, func_out;
   pin_group_pkg::pin_cfg_type [31:0] pin_settings;
   pin_group_pkg::pin_cfg_type cfg_exp [32];
   logic [7:0] fs_exp [16];
   logic [31:0] exp_q [$];
   logic [31:0] d;
   int seed, n_mismatch, total_checks;
   pin_group_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .write_protect_on(write_protect_on),
      .port_dir(port_dir), .port_out(port_out), .pad_in(pad_in), .func_oe(func_oe),
      .func_out(func_out), .pad_oe(pad_oe), .pad_out(pad_out), .pin_settings(pin_settings));
   pin_pad_model pads (.pclk(pclk), .level(level), .pad_in(pad_in), .func_oe(func_oe),
      .func_out(func_out));
   always #10 pclk = ~pclk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // read results are compared in bus order against the noted values
   always @(posedge pclk) begin
      if (psel && penable) begin
         check({31'h0, pslverr}, {31'h0, pwrite & write_protect_on});
      end
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         check(prdata, exp_q.pop_front());
      end
   end
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] v,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the watchdog ends a slave that never answers
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0000_0000, 4'hF);
   endtask : rd
   task automatic batch(input logic [31:0] v, input logic [3:0] s);
      int p;
      apb(1'b1, 32'h0000_00A0, v, s);
      // narrow or protected writes leave the model untouched
      if (s === 4'hF && write_protect_on === 1'b0) begin
         for (int i = 0; i < 16; i++) begin
            p = i + (v[31] ? 16 : 0);
            if (v[i] && v[30]) cfg_exp[p] = {v[22], v[18:16]};
            if (v[i] && v[28] && p[0]) fs_exp[p / 2][7:4] = v[27:24];
            if (v[i] && v[28] && !p[0]) fs_exp[p / 2][3:0] = v[27:24];
         end
      end
   endtask : batch
   task automatic cfg_chk;
      @(posedge pclk);
      for (int i = 0; i < 32; i++) check({28'h0, pin_settings[i]}, {28'h0, cfg_exp[i]});
      for (int n = 0; n < 16; n++) rd(32'h0000_00C0 + 4 * n, {24'h0, fs_exp[n]});
      rd(32'h0000_00A0, 32'h0000_0000);
   endtask : cfg_chk
   task automatic mux_chk;
      logic [31:0] eo, ev, f;
      logic [3:0] c;
      for (int i = 0; i < 32; i++) begin
         c = i[0] ? fs_exp[i / 2][7:4] : fs_exp[i / 2][3:0];
         f = 32'h9E37_79B9 * ({28'h0, c} + 32'h1);
         eo[i] = port_dir[i];
         ev[i] = port_out[i];
         if (cfg_exp[i].function_select_on) begin
            eo[i] = (c <= 4'h8) && (f[i] ^ 32'hA5A5_A5A5 >> i & 1'b1);
            ev[i] = (c <= 4'h8) && f[i];
         end
      end
      check(pad_oe, eo);
      check(pad_out, ev);
   endtask : mux_chk
   initial begin
      seed = 32'hBA0B_4E3B;
      {pclk, presetn, psel, penable, pwrite, write_protect_on} = 6'h00;
      {paddr, pwdata, port_dir, port_out, level, pstrb} = 164'h0;
      foreach (cfg_exp[i]) cfg_exp[i] = '0;
      foreach (fs_exp[i]) fs_exp[i] = 8'h00;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h0000_0090, 32'h0000_0000);
      cfg_chk();
      d = $random(seed);
      apb(1'b1, 32'h0000_0090, d, 4'hF);
      rd(32'h0000_0090, d);
      $display("test reset_and_sampling done");
      for (int j = 0; j < 8; j++) begin
         write_protect_on <= (j == 7);
         batch($random(seed), (j == 6) ? 4'h3 : 4'hF);
      end
      apb(1'b1, 32'h0000_0090, ~d, 4'hF);
      apb(1'b1, 32'h0000_00C0, 32'h0000_00FF, 4'h1);
      rd(32'h0000_0090, d);
      write_protect_on <= 1'b0;
      cfg_chk();
      $display("test batch_write done");
      batch(32'h4001_0003, 4'hF);
      for (int c = 0; c < 16; c++) begin
         port_dir <= $random(seed);
         port_out <= $random(seed);
         apb(1'b1, 32'h0000_00C0, {24'h0, c[3:0], 4'(15 - c)}, 4'h1);
         fs_exp[0] = {c[3:0], 4'(15 - c)};
         repeat (2) @(posedge pclk);
         mux_chk();
      end
      $display("test function_codes done");
      batch(32'h4002_FFFF, 4'hF);
      batch(32'hC002_FFFF, 4'hF);
      port_dir <= 32'h0000_0000;
      apb(1'b1, 32'h0000_0090, 32'h0000_0008, 4'hF);
      for (int k = 0; k < 4; k++) begin
         level <= $random(seed);
         repeat (3) @(posedge pclk);
         rd(32'h0000_0080, level);
      end
      $display("test input_levels done");
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      give_verdict();
   end
endmodule : pin_group_sampling_and_mux_config_test
